// *** hdl/hdtx_pkg.sv ***
// hdtx_pkg: register map, field positions, codes and states of the hdlc transmit controller.
// assumes: single-clock design on sys_clk; registers reached over ahb-lite, one word each.
package hdtx_pkg;

	// register byte addresses, one aligned word each
	localparam logic [7:0] HDTX_OFF_CTRL_A   = 8'h00;
	localparam logic [7:0] HDTX_OFF_CTRL_B   = 8'h04;
	localparam logic [7:0] HDTX_OFF_SUPPRESS = 8'h08;
	localparam logic [7:0] HDTX_OFF_FIFO_CTL = 8'h0c;
	localparam logic [7:0] HDTX_OFF_LIVE     = 8'h10;
	localparam logic [7:0] HDTX_OFF_LATCHED  = 8'h14;
	localparam logic [7:0] HDTX_OFF_MASK     = 8'h18;
	localparam logic [7:0] HDTX_OFF_SPACE    = 8'h1c;
	localparam logic [7:0] HDTX_OFF_DATA     = 8'h20;

	localparam logic [7:0] HDTX_RST_VAL      = 8'h00;

	// hdlc_tx_control_a fields
	localparam int HDTX_CA_CRC_DEFEAT   = 0;
	localparam int HDTX_CA_ZS_DEFEAT    = 1;
	localparam int HDTX_CA_EOM          = 2;
	localparam int HDTX_CA_FILL_SEL     = 3;
	localparam int HDTX_CA_MAP_SEL      = 4;
	localparam int HDTX_CA_CTRL_RESET   = 5;
	localparam int HDTX_CA_END_LOOP     = 6;
	localparam int HDTX_CA_FLAG_CNT     = 7;
	// hdlc_tx_control_b fields
	localparam int HDTX_CB_CHAN_MSB     = 4;
	localparam int HDTX_CB_ENABLE       = 5;
	localparam int HDTX_CB_ABORT        = 7;
	// fifo control field
	localparam int HDTX_FC_WM_MSB       = 1;
	// live and latched status bit positions
	localparam int HDTX_ST_NOT_FULL     = 0;
	localparam int HDTX_ST_BELOW_WM     = 1;
	localparam int HDTX_ST_FULL         = 2;
	localparam int HDTX_ST_EMPTY        = 3;
	localparam int HDTX_EV_MSG_END      = 2;
	localparam int HDTX_EV_UNDERRUN     = 3;
	localparam int HDTX_EV_BITS         = 4;

	// fifo geometry: 64 entries, 7-bit pointers, entry = {loop, eom, data}
	localparam int         HDTX_FIFO_DEPTH = 64;
	localparam int         HDTX_PTR_W      = 7;
	localparam int         HDTX_ENTRY_W    = 10;
	localparam logic [6:0] HDTX_FIFO_SIZE  = 7'h40;
	// ascending low-watermark thresholds for select codes 0..3
	localparam logic [6:0] HDTX_WM_LVL0    = 7'h04;
	localparam logic [6:0] HDTX_WM_LVL1    = 7'h10;
	localparam logic [6:0] HDTX_WM_LVL2    = 7'h20;
	localparam logic [6:0] HDTX_WM_LVL3    = 7'h30;

	// octets on the line
	localparam logic [7:0]  HDTX_FLAG      = 8'h7e;
	localparam logic [7:0]  HDTX_IDLE      = 8'hff;
	localparam logic [7:0]  HDTX_ABORT     = 8'hfe;
	localparam logic [15:0] HDTX_CRC_INIT  = 16'hffff;
	localparam logic [15:0] HDTX_CRC_POLY  = 16'h8408;
	localparam logic [2:0]  HDTX_STUFF_RUN = 3'h5;
	localparam logic [2:0]  HDTX_LAST_BIT  = 3'h7;

	// sa bit numbering on the framer side; 0 means an fdl bit
	localparam logic [3:0]  HDTX_SA_LOW    = 4'h4;
	localparam logic [3:0]  HDTX_SA_HIGH   = 4'h8;

	typedef enum logic [2:0] {
		HDTX_ST_FILL  = 3'b000,
		HDTX_ST_FLAGS = 3'b001,
		HDTX_ST_DATA  = 3'b010,
		HDTX_ST_CRC   = 3'b011,
		HDTX_ST_ABORT = 3'b100
	} hdtx_state_e;

endpackage : hdtx_pkg

// *** hdl/hdtx_controller.sv ***
// hdtx_controller: transmit hdlc controller with 64-byte fifo, ahb-lite register slave,
// bit serialiser into a framer time slot or the fdl/sa overhead bits.
// assumes: framer strobes one bit opportunity at a time on sys_clk; zero-wait ahb-lite master.
// Function
// - append two crc bytes unless defeated
// - stuff zero after five ones unless defeated
// - end-of-message mark closes message after byte
// - fill with 7e or ff between messages
// - mapping select: channel or fdl/sa bits
// - reset bit edge flushes fifo, sends abort
// - end-and-loop repeats the message with crc
// - loop ends on clear or new message
// - one or two flags between messages
// - five-bit channel select and enable bit
// - abort bit edge flushes, sends one fe
// - eight suppress bits block slot bit positions
// - below-watermark live while fill under threshold
// - live status: not-full, below, full, empty
// - latched bits hold until read
// - write ones clears only those latched bits
// - masked latched events pull int_n low
// - not-full and watermark events on rising edge
// - message-end event after message sent
// - empty before end mark: underrun, abort
// - seven-bit free space count, reset zero
// - data register pushes byte, bit0 lsb
`timescale 1ns/1ns
module hdtx_controller
	import hdtx_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        fr_bit_strobe,
	input  wire logic [4:0]  fr_chan,
	input  wire logic [2:0]  fr_bit_pos,
	input  wire logic        fr_oh_bit,
	input  wire logic [3:0]  fr_sa_num,
	output logic             hdlc_bit,
	output logic             hdlc_bit_valid,
	output logic             int_n
);

	////////////////////////////////////////////////////////////////////////////////
	// registers and state
	logic [7:0]              ctrl_a_reg, ctrl_b_reg, supp_reg, fifo_ctl_reg, mask_reg;
	logic [HDTX_EV_BITS-1:0] lat_reg, lat_next;
	logic [6:0]              space_reg;
	logic [31:0]             rdata_reg;
	logic                    wr_pend_reg;
	logic [7:0]              wr_addr_reg;
	logic                    abort_prev_reg, creset_prev_reg;
	logic                    nf_prev_reg, bw_prev_reg;
	logic [HDTX_ENTRY_W-1:0] mem_reg [HDTX_FIFO_DEPTH];
	logic [HDTX_PTR_W-1:0]   wr_ptr_reg, rd_ptr_reg, msg_start_reg;
	hdtx_state_e             state_reg, state_next;
	logic [7:0]              sh_reg, sh_next;
	logic [2:0]              cnt_reg, ones_reg;
	logic [15:0]             crc_reg;
	logic [7:0]              crc_hi_reg;
	logic                    crc_hi_pend_reg, eom_reg, loop_reg, extra_flag_reg, extra_next;
	logic                    out_bit_reg, out_valid_reg;

	////////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: zero wait, always okay; reads are taken in the address phase
	wire        addr_ok  = hsel && htrans[1] && hready;
	wire        rd_req   = addr_ok && !hwrite;
	wire        wr_data  = wr_pend_reg;
	wire [7:0]  wbyte    = hwdata[7:0];
	wire        wr_ca    = wr_data && (wr_addr_reg == HDTX_OFF_CTRL_A);
	wire        wr_cb    = wr_data && (wr_addr_reg == HDTX_OFF_CTRL_B);
	wire        wr_sup   = wr_data && (wr_addr_reg == HDTX_OFF_SUPPRESS);
	wire        wr_fc    = wr_data && (wr_addr_reg == HDTX_OFF_FIFO_CTL);
	wire        wr_lat   = wr_data && (wr_addr_reg == HDTX_OFF_LATCHED);
	wire        wr_mask  = wr_data && (wr_addr_reg == HDTX_OFF_MASK);
	wire        wr_fifo  = wr_data && (wr_addr_reg == HDTX_OFF_DATA);
	wire        rd_lat   = rd_req && (haddr == HDTX_OFF_LATCHED);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// fifo level and live status
	wire [6:0] fill_w    = wr_ptr_reg - rd_ptr_reg;
	wire [6:0] space_w   = HDTX_FIFO_SIZE - fill_w;
	wire       empty_w   = (fill_w == 7'h00);
	wire       full_w    = (fill_w == HDTX_FIFO_SIZE);
	wire       nfull_w   = !full_w;
	wire [1:0] wm_sel    = fifo_ctl_reg[HDTX_FC_WM_MSB:0];
	wire [6:0] wm_lvl    = (wm_sel == 2'h0) ? HDTX_WM_LVL0 :
	                       (wm_sel == 2'h1) ? HDTX_WM_LVL1 :
	                       (wm_sel == 2'h2) ? HDTX_WM_LVL2 : HDTX_WM_LVL3;
	wire       below_w   = (fill_w < wm_lvl);
	wire [7:0] live_w    = {4'h0, empty_w, full_w, below_w, nfull_w};
	wire [7:0] rd_mux    = (haddr == HDTX_OFF_CTRL_A)   ? ctrl_a_reg :
	                       (haddr == HDTX_OFF_CTRL_B)   ? ctrl_b_reg :
	                       (haddr == HDTX_OFF_SUPPRESS) ? supp_reg :
	                       (haddr == HDTX_OFF_FIFO_CTL) ? fifo_ctl_reg :
	                       (haddr == HDTX_OFF_LIVE)     ? live_w :
	                       (haddr == HDTX_OFF_LATCHED)  ? {4'h0, lat_reg} :
	                       (haddr == HDTX_OFF_MASK)     ? mask_reg :
	                       (haddr == HDTX_OFF_SPACE)    ? {1'b0, space_reg} : 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// control edges: reset and abort act on a 0-to-1 change only
	wire creset_edge = ctrl_a_reg[HDTX_CA_CTRL_RESET] && !creset_prev_reg;
	wire abort_edge  = ctrl_b_reg[HDTX_CB_ABORT] && !abort_prev_reg;
	wire flush       = creset_edge || abort_edge;
	wire push        = wr_fifo && !full_w;
	wire ctl_enable  = ctrl_b_reg[HDTX_CB_ENABLE];
	wire zs_defeat   = ctrl_a_reg[HDTX_CA_ZS_DEFEAT];
	wire two_flags   = ctrl_a_reg[HDTX_CA_FLAG_CNT];
	wire [7:0] fill_byte = ctrl_a_reg[HDTX_CA_FILL_SEL] ? HDTX_IDLE : HDTX_FLAG;

	////////////////////////////////////////////////////////////////////////////////
	// slot selection: which framer bit opportunities carry hdlc bits
	wire [3:0] sa_idx   = HDTX_SA_HIGH - fr_sa_num;
	wire       sa_range = (fr_sa_num >= HDTX_SA_LOW) && (fr_sa_num <= HDTX_SA_HIGH);
	wire       oh_ok    = fr_oh_bit && ((fr_sa_num == 4'h0) ||
	                      (sa_range && !supp_reg[sa_idx[2:0]]));
	wire       ch_ok    = !fr_oh_bit && (fr_chan == ctrl_b_reg[HDTX_CB_CHAN_MSB:0]) &&
	                      !supp_reg[fr_bit_pos];
	wire       slot_ok  = ctrl_a_reg[HDTX_CA_MAP_SEL] ? oh_ok : ch_ok;
	wire       tick     = fr_bit_strobe && ctl_enable && slot_ok;

	////////////////////////////////////////////////////////////////////////////////
	// bit engine: stuffing, crc and byte boundaries
	// a pending stuff is honoured even on the first flag bit after the crc
	wire        stuff_now = !zs_defeat && (ones_reg == HDTX_STUFF_RUN);
	wire        tx_bit    = stuff_now ? 1'b0 : sh_reg[0];
	wire        in_msg    = (state_reg == HDTX_ST_DATA) || (state_reg == HDTX_ST_CRC);
	wire        crc_fb    = crc_reg[0] ^ sh_reg[0];
	wire [15:0] crc_upd   = {1'b0, crc_reg[15:1]} ^ (crc_fb ? HDTX_CRC_POLY : 16'h0000);
	wire        byte_done = tick && !stuff_now && (cnt_reg == HDTX_LAST_BIT);
	wire [HDTX_ENTRY_W-1:0] head = mem_reg[rd_ptr_reg[5:0]];
	// loop restarts only while nothing new waits in the fifo
	wire loop_again = loop_reg && ctrl_a_reg[HDTX_CA_END_LOOP] && empty_w;
	logic pop, restart, msg_end, underrun, load_crc;
	always_comb begin
		state_next = state_reg;
		sh_next    = fill_byte;
		extra_next = 1'b0;
		pop        = 1'b0;
		restart    = 1'b0;
		msg_end    = 1'b0;
		underrun   = 1'b0;
		load_crc   = 1'b0;
		case (state_reg)
			HDTX_ST_FILL: begin
				if (!empty_w) begin
					state_next = HDTX_ST_FLAGS;
					sh_next    = HDTX_FLAG;
				end
			end
			HDTX_ST_FLAGS: begin
				if (extra_flag_reg) begin
					sh_next = HDTX_FLAG;
				end else if (!empty_w) begin
					state_next = HDTX_ST_DATA;
					sh_next    = head[7:0];
					pop        = 1'b1;
				end else begin
					state_next = HDTX_ST_FILL;
				end
			end
			HDTX_ST_DATA: begin
				if (eom_reg && !ctrl_a_reg[HDTX_CA_CRC_DEFEAT]) begin
					state_next = HDTX_ST_CRC;
					sh_next    = ~crc_upd[7:0];
					load_crc   = 1'b1;
				end else if (eom_reg) begin
					state_next = HDTX_ST_FLAGS;
					sh_next    = HDTX_FLAG;
					extra_next = two_flags;
					msg_end    = 1'b1;
					restart    = loop_again;
				end else if (!empty_w) begin
					sh_next = head[7:0];
					pop     = 1'b1;
				end else begin
					state_next = HDTX_ST_ABORT;
					sh_next    = HDTX_ABORT;
					underrun   = 1'b1;
				end
			end
			HDTX_ST_CRC: begin
				if (crc_hi_pend_reg) begin
					sh_next = crc_hi_reg;
				end else begin
					state_next = HDTX_ST_FLAGS;
					sh_next    = HDTX_FLAG;
					extra_next = two_flags;
					msg_end    = 1'b1;
					restart    = loop_again;
				end
			end
			HDTX_ST_ABORT: begin
				state_next = HDTX_ST_FILL;
			end
			default: begin
				state_next = HDTX_ST_FILL;
			end
		endcase
	end

	wire do_pop     = byte_done && pop;
	wire do_restart = byte_done && restart;
	wire ev_end     = byte_done && msg_end;
	wire ev_udr     = byte_done && underrun;
	always_ff @(posedge sys_clk) begin
		if (!nrst || flush) begin
			state_reg <= flush ? HDTX_ST_ABORT : HDTX_ST_FILL;
			sh_reg    <= flush ? HDTX_ABORT : HDTX_IDLE;
			cnt_reg   <= 3'h0;
			ones_reg  <= 3'h0;
		end else if (tick) begin
			ones_reg <= (stuff_now || !tx_bit || !in_msg || zs_defeat) ? 3'h0 : ones_reg + 3'h1;
			if (byte_done) begin
				state_reg <= state_next;
				sh_reg    <= sh_next;
				cnt_reg   <= 3'h0;
			end else if (!stuff_now) begin
				sh_reg  <= {1'b0, sh_reg[7:1]};
				cnt_reg <= cnt_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			crc_reg         <= HDTX_CRC_INIT;
			crc_hi_reg      <= 8'h00;
			crc_hi_pend_reg <= 1'b0;
			eom_reg         <= 1'b0;
			loop_reg        <= 1'b0;
			extra_flag_reg  <= 1'b0;
		end else if (tick && !stuff_now) begin
			if (state_reg == HDTX_ST_DATA)
				crc_reg <= crc_upd;
			if (byte_done && state_reg != HDTX_ST_DATA)
				crc_reg <= HDTX_CRC_INIT;
			if (byte_done) begin
				extra_flag_reg  <= extra_next;
				crc_hi_pend_reg <= load_crc;
				if (load_crc)
					crc_hi_reg <= ~crc_upd[15:8];
				if (do_pop) begin
					eom_reg  <= head[8];
					loop_reg <= head[9];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fifo storage and pointers
	always_ff @(posedge sys_clk) begin
		if (push)
			mem_reg[wr_ptr_reg[5:0]] <= {ctrl_a_reg[HDTX_CA_END_LOOP],
			                            ctrl_a_reg[HDTX_CA_EOM] | ctrl_a_reg[HDTX_CA_END_LOOP], wbyte};
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			wr_ptr_reg    <= 7'h00;
			rd_ptr_reg    <= 7'h00;
			msg_start_reg <= 7'h00;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 7'h01;
			if (flush)
				rd_ptr_reg <= wr_ptr_reg;
			else if (do_restart)
				rd_ptr_reg <= msg_start_reg;
			else if (do_pop)
				rd_ptr_reg <= rd_ptr_reg + 7'h01;
			if (do_pop && state_reg == HDTX_ST_FLAGS)
				msg_start_reg <= rd_ptr_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register file, latched events and interrupt
	wire [HDTX_EV_BITS-1:0] ev_set = {ev_udr, ev_end,
	                                  below_w && !bw_prev_reg, nfull_w && !nf_prev_reg};
	wire [HDTX_EV_BITS-1:0] ev_clr = (rd_lat ? {HDTX_EV_BITS{1'b1}} : '0) |
	                                 (wr_lat ? wbyte[HDTX_EV_BITS-1:0] : '0);
	assign lat_next = (lat_reg & ~ev_clr) | ev_set;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl_a_reg   <= HDTX_RST_VAL;
			ctrl_b_reg   <= HDTX_RST_VAL;
			supp_reg     <= HDTX_RST_VAL;
			fifo_ctl_reg <= HDTX_RST_VAL;
			mask_reg     <= HDTX_RST_VAL;
		end else begin
			if (wr_ca)   ctrl_a_reg   <= wbyte;
			if (wr_cb)   ctrl_b_reg   <= wbyte;
			if (wr_sup)  supp_reg     <= wbyte;
			if (wr_fc)   fifo_ctl_reg <= wbyte;
			if (wr_mask) mask_reg     <= wbyte;
		end
	end

	// previous levels start at "already true" so reset itself raises no event
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			lat_reg         <= '0;
			nf_prev_reg     <= 1'b1;
			bw_prev_reg     <= 1'b1;
			abort_prev_reg  <= 1'b0;
			creset_prev_reg <= 1'b0;
			space_reg       <= 7'h00;
			rdata_reg       <= 32'h0000_0000;
			wr_pend_reg     <= 1'b0;
			wr_addr_reg     <= 8'h00;
		end else begin
			lat_reg         <= lat_next;
			nf_prev_reg     <= nfull_w;
			bw_prev_reg     <= below_w;
			abort_prev_reg  <= ctrl_b_reg[HDTX_CB_ABORT];
			creset_prev_reg <= ctrl_a_reg[HDTX_CA_CTRL_RESET];
			space_reg       <= space_w;
			wr_pend_reg     <= addr_ok && hwrite;
			wr_addr_reg     <= haddr;
			if (rd_req)
				rdata_reg <= {24'h000000, rd_mux};
		end
	end

	assign int_n = !(|(lat_reg & mask_reg[HDTX_EV_BITS-1:0]));

	////////////////////////////////////////////////////////////////////////////////
	// serial output towards the framer
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			out_bit_reg   <= 1'b1;
			out_valid_reg <= 1'b0;
		end else begin
			out_valid_reg <= tick;
			if (tick)
				out_bit_reg <= tx_bit;
		end
	end

	assign hdlc_bit       = out_bit_reg;
	assign hdlc_bit_valid = out_valid_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	logic [2:0] run_reg;
	always_ff @(posedge sys_clk) begin
		if (!nrst)
			run_reg <= 3'h0;
		else if (tick)
			run_reg <= (tx_bit && in_msg) ? ((run_reg == HDTX_LAST_BIT) ? run_reg : run_reg + 3'h1) : 3'h0;
	end
	a_stuff_run: assert property (@(posedge sys_clk) disable iff (!nrst)
		!zs_defeat |-> run_reg <= HDTX_STUFF_RUN) else $error("more than five ones inside a message");
	a_full_space: assert property (@(posedge sys_clk) disable iff (!nrst)
		full_w |=> (space_reg == 7'h00) || $past(push) || $past(do_pop) || $past(flush))
		else $error("full fifo but space count not zero");
	a_abort_flush: assert property (@(posedge sys_clk) disable iff (!nrst)
		abort_edge |=> empty_w && state_reg == HDTX_ST_ABORT && sh_reg == HDTX_ABORT)
		else $error("abort did not flush and send fe");
	a_reset_flush: assert property (@(posedge sys_clk) disable iff (!nrst)
		creset_edge |=> empty_w && state_reg == HDTX_ST_ABORT) else $error("controller reset did not flush");
	a_udr_event: assert property (@(posedge sys_clk) disable iff (!nrst)
		ev_udr && !flush |=> lat_reg[HDTX_EV_UNDERRUN] && state_reg == HDTX_ST_ABORT)
		else $error("underrun not flagged with abort");
	a_end_event: assert property (@(posedge sys_clk) disable iff (!nrst)
		ev_end |=> lat_reg[HDTX_EV_MSG_END]) else $error("message end not latched");
	a_nf_edge: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(nfull_w) |-> ##0 lat_reg[HDTX_ST_NOT_FULL] ##1 1'b1 or ##1 lat_reg[HDTX_ST_NOT_FULL])
		else $error("not-full edge not latched");
	a_irq_low: assert property (@(posedge sys_clk) disable iff (!nrst)
		ev_end && mask_reg[HDTX_EV_MSG_END] |=> !int_n) else $error("masked-in event left int_n high");
	a_slot_claim: assert property (@(posedge sys_clk) disable iff (!nrst)
		fr_bit_strobe && ctl_enable && !ctrl_a_reg[HDTX_CA_MAP_SEL] && !fr_oh_bit &&
		fr_chan == ctrl_b_reg[HDTX_CB_CHAN_MSB:0] |=> hdlc_bit_valid == !$past(supp_reg[fr_bit_pos]))
		else $error("slot bit claim disagrees with suppress mask");

	c_msg_end: cover property (@(posedge sys_clk) disable iff (!nrst) ev_end);
	c_loop: cover property (@(posedge sys_clk) disable iff (!nrst) do_restart);
	c_underrun: cover property (@(posedge sys_clk) disable iff (!nrst) ev_udr);
	c_stuff: cover property (@(posedge sys_clk) disable iff (!nrst) tick && stuff_now && in_msg);

endmodule : hdtx_controller

// *** test/hdtx_framer_model.sv ***
// hdtx_framer_model: framer transmit slot stream, one bit opportunity per cycle.
// assumes: shares sys_clk with the controller; slot 31 carries the overhead bits.
`timescale 1ns/1ns
module hdtx_framer_model (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        hdlc_bit,
	input  wire logic        hdlc_bit_valid,
	output logic             fr_bit_strobe,
	output logic [4:0]       fr_chan,
	output logic [2:0]       fr_bit_pos,
	output logic             fr_oh_bit,
	output logic [3:0]       fr_sa_num,
	output logic [47:0]      line_hist
);
	logic [7:0] slot_reg;
	assign fr_bit_strobe = nrst;
	assign fr_chan       = slot_reg[7:3];
	assign fr_bit_pos    = slot_reg[2:0];
	// overhead slot: positions 0..4 are sa4..sa8, the rest fdl bits
	assign fr_oh_bit     = (slot_reg[7:3] == 5'h1f);
	assign fr_sa_num     = (slot_reg[2:0] < 3'h5) ? 4'h4 + {1'b0, slot_reg[2:0]} : 4'h0;
	always_ff @(posedge sys_clk) begin
		slot_reg <= nrst ? slot_reg + 8'h01 : 8'h00;
		// newest bit enters at the top, so bytes read lsb first from the bottom
		if (hdlc_bit_valid)
			line_hist <= {hdlc_bit, line_hist[47:1]};
	end
endmodule : hdtx_framer_model

// *** test/tb_hdlc_transmit_controller.sv ***
// tb_hdlc_transmit_controller: registers, fifo levels, events and line framing.
// assumes: one ahb-lite slave, framer model on the slot side.
`timescale 1ns/1ns
`define CHK(nm, e, s) begin checked++; if ((e) !== (s)) begin n_mismatch++; \
	$display("wrong value %s exp %h got %h", nm, e, s); end end
module tb_hdlc_transmit_controller;
	import hdtx_pkg::*;
	logic        sys_clk = 0, nrst = 0, hsel = 0, hwrite = 0, en = 0, map = 0, claim_q = 0;
	logic [7:0]  haddr = 0, sup = 0, q;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 0, hrdata, rnd = 32'h3fc05a85;
	logic        hreadyout, hresp, hdlc_bit, hdlc_bit_valid, int_n, strobe, oh;
	logic [4:0]  fchan, chan = 0;
	logic [2:0]  pos;
	logic [3:0]  sa;
	logic [47:0] hist;
	logic [6:0]  wm_tab [4] = '{HDTX_WM_LVL0, HDTX_WM_LVL1, HDTX_WM_LVL2, HDTX_WM_LVL3};
	logic [7:0]  rst_exp [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0b, 8'h00, 8'h00, 8'h40, 8'h00};
	int          n_mismatch = 0, checked = 0;
	wire         claim_now = strobe && en && (map ? oh && (sa == 4'h0 || !sup[4'h8 - sa])
		: !oh && fchan == chan && !sup[pos]);
	always #20 sys_clk = ~sys_clk;
	hdtx_controller u_hdtx_controller (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fr_bit_strobe(strobe), .fr_chan(fchan),
		.fr_bit_pos(pos), .fr_oh_bit(oh), .fr_sa_num(sa), .hdlc_bit(hdlc_bit),
		.hdlc_bit_valid(hdlc_bit_valid), .int_n(int_n));
	hdtx_framer_model u_hdtx_framer_model (.sys_clk(sys_clk), .nrst(nrst), .hdlc_bit(hdlc_bit),
		.hdlc_bit_valid(hdlc_bit_valid), .fr_bit_strobe(strobe), .fr_chan(fchan), .fr_bit_pos(pos),
		.fr_oh_bit(oh), .fr_sa_num(sa), .line_hist(hist));
	// a bit may only come out for an opportunity the configuration gives away
	always @(posedge sys_clk) begin
		if (hdlc_bit_valid)
			`CHK("claimed slot", 1'b1, claim_q)
		claim_q <= claim_now;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	function automatic logic [15:0] fcs(input logic [7:0] b);
		logic [15:0] c;
		c = HDTX_CRC_INIT;
		for (int i = 0; i < 8; i++)
			c = (c >> 1) ^ ((c[0] ^ b[i]) ? HDTX_CRC_POLY : 16'h0000);
		return ~c;
	endfunction : fcs
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= w;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1)
			@(posedge sys_clk);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		@(posedge sys_clk);
		while (hreadyout !== 1'b1)
			@(posedge sys_clk);
		q = hrdata[7:0];
	endtask : bus
	task rx(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK("register", e, q)
	endtask : rx
	task push(input logic [7:0] d);
		bus(1'b1, HDTX_OFF_DATA, d);
		`CHK("hresp", 1'b0, hresp)
	endtask : push
	task flush;
		bus(1'b1, HDTX_OFF_CTRL_A, 8'h20);
		bus(1'b1, HDTX_OFF_CTRL_A, 8'h00);
	endtask : flush
	// waits for the last n line bits, oldest in bit 0, to show the pattern
	task line(input int n, input logic [47:0] p);
		for (int t = 0; t < 20000 && (hist >> (48 - n)) !== p; t++)
			@(posedge sys_clk);
		`CHK("line bits", p, hist >> (48 - n))
	endtask : line
	task stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	initial begin
		#4000000;
		n_mismatch++;
		stop_test;
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < 9; i++)
			rx(8'(i * 4), rst_exp[i]);
		for (int i = 0; i < 4; i++) begin
			rnd = xs(rnd);
			bus(1'b1, HDTX_OFF_SUPPRESS, rnd[7:0]);
			rx(HDTX_OFF_SUPPRESS, rnd[7:0]);
		end
		// all four events unmasked, so message end and underrun also reach int_n
		bus(1'b1, HDTX_OFF_MASK, 8'h0f);
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, HDTX_OFF_FIFO_CTL, 8'(c));
			for (int i = 1; i < int'(wm_tab[c]); i++)
				push(8'(i));
			rx(HDTX_OFF_LIVE, 8'h03);
			push(8'h55);
			rx(HDTX_OFF_LIVE, 8'h01);
			rx(HDTX_OFF_SPACE, 8'h40 - {1'b0, wm_tab[c]});
			flush;
			rx(HDTX_OFF_LATCHED, 8'h02);
		end
		// one byte past full must be dropped
		for (int i = 0; i < 65; i++)
			push(8'(i));
		rx(HDTX_OFF_LIVE, 8'h04);
		rx(HDTX_OFF_SPACE, 8'h00);
		flush;
		`CHK("int_n", 1'b0, int_n)
		bus(1'b1, HDTX_OFF_LATCHED, 8'h01);
		rx(HDTX_OFF_LATCHED, 8'h02);
		`CHK("int_n", 1'b1, int_n)
		rx(HDTX_OFF_LATCHED, 8'h00);
		rnd = xs(rnd);
		bus(1'b1, HDTX_OFF_SUPPRESS, rnd[15:8] & 8'h7e);
		bus(1'b1, HDTX_OFF_CTRL_B, {3'b001, rnd[4:0] % 5'h1f});
		sup  <= rnd[15:8] & 8'h7e;
		chan <= rnd[4:0] % 5'h1f;
		en   <= 1'b1;
		bus(1'b1, HDTX_OFF_CTRL_A, 8'h05);
		push(8'hff);
		line(25, {8'h7e, 9'h1df, 8'h7e});
		rx(HDTX_OFF_LATCHED, 8'h04);
		bus(1'b1, HDTX_OFF_CTRL_A, 8'h06);
		push(8'ha5);
		line(40, {8'h7e, fcs(8'ha5), 8'ha5, 8'h7e});
		bus(1'b1, HDTX_OFF_CTRL_A, 8'hc3);
		push(8'h81);
		line(32, {8'h81, 8'h7e, 8'h7e, 8'h81});
		bus(1'b1, HDTX_OFF_CTRL_A, 8'h83);
		line(32, {4{8'h7e}});
		bus(1'b0, HDTX_OFF_LATCHED, 8'h00);
		bus(1'b1, HDTX_OFF_CTRL_A, 8'h18);
		map <= 1'b1;
		push(rnd[23:16]);
		push(rnd[31:24]);
		line(16, {8'hff, 8'hfe});
		bus(1'b0, HDTX_OFF_LATCHED, 8'h00);
		`CHK("underrun", 1'b1, q[HDTX_EV_UNDERRUN])
		bus(1'b1, HDTX_OFF_CTRL_A, 8'h00);
		map <= 1'b0;
		for (int i = 0; i < 3; i++)
			push(8'h0f);
		bus(1'b1, HDTX_OFF_CTRL_B, {3'b101, chan});
		// the space count is registered: the flush needs one more edge to show
		@(posedge sys_clk);
		rx(HDTX_OFF_SPACE, 8'h40);
		line(16, {8'h7e, 8'hfe});
		stop_test;
	end
endmodule : tb_hdlc_transmit_controller
